// file: logic/usb_irq_regs.svh
// Register offsets, field positions, masks and reset values of the device interrupt block
`ifndef USB_IRQ_REGS_SVH
`define USB_IRQ_REGS_SVH

// Device one register offsets
`define OFS_D1_ENABLE    16'hc08c
`define OFS_D1_ADDRESS   16'hc08e
`define OFS_D1_FLAGS     16'hc090

// Device two register offsets
`define OFS_D2_ENABLE    16'hc0ac
`define OFS_D2_ADDRESS   16'hc0ae
`define OFS_D2_FLAGS     16'hc0b0

// Field positions in the enable, flag and address words
`define BIT_VBUS         15
`define BIT_ID           14
`define BIT_TMO_EN       11
`define BIT_SOF          9
`define BIT_USB_RST      8
`define ADDR_MSB         6

// Implemented bits; everything else is reserved
`define MASK_EN_D1       16'hcbff
`define MASK_EN_D2       16'h0bff
`define MASK_FLAGS_D1    16'hc3ff
`define MASK_FLAGS_D2    16'h03ff

// Reset values
`define RST_ENABLE       16'h0000
`define RST_ADDRESS      7'h00
`define RST_FLAGS        16'h0000

// Cycles from a read strobe to its data
`define RD_LATENCY       1

`endif

// file: logic/usb_irq_pkg.sv
// Types shared by the device interrupt and address block
`default_nettype none
package usb_irq_pkg;

	// One register word
	typedef logic [15:0] word_t;

	// Seven-bit USB device address
	typedef logic [6:0] usb_addr_t;

	// Kind of register an offset selects
	typedef enum logic [1:0] {REG_NONE, REG_ENABLE, REG_ADDRESS, REG_FLAGS} reg_kind_t;

	// Decoded register select
	typedef struct packed {
		logic      dev_two;
		reg_kind_t kind;
	} reg_sel_t;

	// State of one device instance
	typedef struct packed {
		word_t     enables;
		usb_addr_t address;
		word_t     flags;
		logic      irq;
	} unit_state_t;

	// State of the top level
	typedef struct packed {
		word_t       cpu_rdata;
		logic        cpu_rvalid;
		word_t       hp_rdata;
		logic        hp_rvalid;
		logic [1:0]  otg_prev;
		logic        primed;
		logic [1:0]  match;
	} top_state_t;

endpackage

`default_nettype wire

// file: logic/dev_irq_unit.sv
// One device instance: enable, address and sticky flag registers
`timescale 1ns/1ps
`default_nettype none
`include "usb_irq_regs.svh"

module dev_irq_unit #(
	parameter bit HAS_OTG = 1'b1                   // VBUS and ID flags exist
)(
	input  wire logic                   clk_i,     // System clock
	input  wire logic                   rst_i,     // Synchronous reset
	input  wire logic                   ce_i,      // Clock enable
	input  wire logic                   en_we_i,   // Enable register write
	input  wire logic                   addr_we_i, // Address register write
	input  wire usb_irq_pkg::word_t     wdata_i,   // Write data
	input  wire usb_irq_pkg::word_t     clr_i,     // Flags to clear
	input  wire usb_irq_pkg::word_t     set_i,     // Flags to set
	output var  usb_irq_pkg::word_t     enables_o, // Enable register
	output var  usb_irq_pkg::usb_addr_t address_o, // Device address
	output var  usb_irq_pkg::word_t     flags_o,   // Flag register
	output var  logic                   irq_o      // Interrupt request
);
	import usb_irq_pkg::*;

	// Implemented bits depend on the instance
	localparam word_t EN_MASK   = HAS_OTG ? `MASK_EN_D1 : `MASK_EN_D2;
	localparam word_t FLAG_MASK = HAS_OTG ? `MASK_FLAGS_D1 : `MASK_FLAGS_D2;
	localparam unit_state_t RST_STATE = '{enables: `RST_ENABLE, address: `RST_ADDRESS,
		flags: `RST_FLAGS, irq: 1'b0};

	unit_state_t s_q;   // Registered state
	unit_state_t s_d;   // Next state

	// Next-state logic
	always_comb
	begin
		s_d = s_q;
		// Reserved enable bits stay zero
		if (en_we_i)
		begin
			s_d.enables = wdata_i & EN_MASK;
		end
		// Only the seven address bits are kept
		if (addr_we_i)
		begin
			s_d.address = wdata_i[`ADDR_MSB:0];
		end
		// Set wins over a clear in the same cycle
		s_d.flags = ((s_q.flags & ~clr_i) | set_i) & FLAG_MASK;
		// Request follows the new flags, so it lines up with them
		s_d.irq = |(s_d.flags & s_d.enables);
	end

	// State register
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			s_q <= RST_STATE;
		end
		else if (ce_i)
		begin
			s_q <= s_d;
		end
	end

	assign enables_o = s_q.enables;
	assign address_o = s_q.address;
	assign flags_o   = s_q.flags;
	assign irq_o     = s_q.irq;

endmodule

`default_nettype wire

// file: logic/usb_device_irq_and_address.sv
// Top: two device instances, processor and external host port access, address match
`timescale 1ns/1ps
`default_nettype none
`include "usb_irq_regs.svh"

// Behaviour
// - Endpoint enable bit gates its done interrupt
// - ACK, STALL, timeout, exceptions raise done
// - NAK raises done when NAK enable set
// - Address register: write-only seven-bit field
// - Device address resets to zero
// - Respond only to own stored address
// - Writing one clears flag, zero keeps
// - External host port reads, clears status
// - Bit fifteen flags both VBUS edges
// - Bit fourteen flags both ID edges
// - VBUS, ID flags only in device one
// - Bit nine flags SOF/EOP received
// - Bit eight flags USB reset detected
// - Bits seven..zero flag endpoint done
// - Two devices with separate register sets
module usb_device_irq_and_address (
	input  wire logic                   MCLK_I,          // System clock, 200 MHz
	input  wire logic                   SYS_RST_I,       // Synchronous reset, high
	input  wire logic                   CE_I,            // Clock enable, freezes all state

	// Processor register access
	input  wire usb_irq_pkg::word_t     CPU_ADDR_I,      // Register offset
	input  wire logic                   CPU_WR_I,        // Write strobe
	input  wire logic                   CPU_RD_I,        // Read strobe
	input  wire usb_irq_pkg::word_t     CPU_WDATA_I,     // Write data
	output var  usb_irq_pkg::word_t     CPU_RDATA_O,     // Read data
	output var  logic                   CPU_RVALID_O,    // Read data valid pulse

	// External host port access
	input  wire usb_irq_pkg::word_t     HP_ADDR_I,       // Register offset
	input  wire logic                   HP_WR_I,         // Write strobe
	input  wire logic                   HP_RD_I,         // Read strobe
	input  wire usb_irq_pkg::word_t     HP_WDATA_I,      // Write data
	output var  usb_irq_pkg::word_t     HP_RDATA_O,      // Read data
	output var  logic                   HP_RVALID_O,     // Read data valid pulse

	// Device one endpoint and bus events
	input  wire logic [7:0]             D1_EP_RESULT_I,  // ACK, STALL, timeout or error per endpoint
	input  wire logic [7:0]             D1_EP_NAK_I,     // NAK sent per endpoint
	input  wire logic [7:0]             D1_EP_NAK_IE_I,  // NAK interrupt enable per endpoint
	input  wire logic                   D1_SOF_I,        // SOF/EOP received pulse
	input  wire logic                   D1_USB_RST_I,    // USB reset detected pulse

	// Device two endpoint and bus events
	input  wire logic [7:0]             D2_EP_RESULT_I,  // ACK, STALL, timeout or error per endpoint
	input  wire logic [7:0]             D2_EP_NAK_I,     // NAK sent per endpoint
	input  wire logic [7:0]             D2_EP_NAK_IE_I,  // NAK interrupt enable per endpoint
	input  wire logic                   D2_SOF_I,        // SOF/EOP received pulse
	input  wire logic                   D2_USB_RST_I,    // USB reset detected pulse

	// OTG levels on the first port of device one
	input  wire logic                   VBUS_ABOVE_I,    // VBUS above 4.4 V
	input  wire logic                   OTG_ID_I,        // OTG ID pin level

	// Token address checks
	input  wire logic                   D1_TOKEN_I,      // Device one token seen pulse
	input  wire usb_irq_pkg::usb_addr_t D1_TOKEN_ADDR_I, // Device one token address
	input  wire logic                   D2_TOKEN_I,      // Device two token seen pulse
	input  wire usb_irq_pkg::usb_addr_t D2_TOKEN_ADDR_I, // Device two token address
	output var  logic                   D1_ADDR_MATCH_O, // Device one should answer
	output var  logic                   D2_ADDR_MATCH_O, // Device two should answer

	// Interrupt requests
	output var  logic                   D1_IRQ_O,        // Device one request
	output var  logic                   D2_IRQ_O         // Device two request
);
	import usb_irq_pkg::*;

	// Reset value of the top-level state
	localparam top_state_t RST_STATE = '{cpu_rdata: 16'h0000, cpu_rvalid: 1'b0,
		hp_rdata: 16'h0000, hp_rvalid: 1'b0, otg_prev: 2'h0, primed: 1'b0, match: 2'h0};

	// Map an offset onto a device and register kind
	function automatic reg_sel_t decode(input word_t addr);
		reg_sel_t sel;
		sel = '{dev_two: 1'b0, kind: REG_NONE};
		// Device one registers
		if (addr == `OFS_D1_ENABLE)
		begin
			sel.kind = REG_ENABLE;
		end
		// Device one write-only address word
		else if (addr == `OFS_D1_ADDRESS)
		begin
			sel.kind = REG_ADDRESS;
		end
		// Device one sticky flag word
		else if (addr == `OFS_D1_FLAGS)
		begin
			sel.kind = REG_FLAGS;
		end
		// Device two registers
		else if (addr == `OFS_D2_ENABLE)
		begin
			sel = '{dev_two: 1'b1, kind: REG_ENABLE};
		end
		// Device two write-only address word
		else if (addr == `OFS_D2_ADDRESS)
		begin
			sel = '{dev_two: 1'b1, kind: REG_ADDRESS};
		end
		// Device two sticky flag word
		else if (addr == `OFS_D2_FLAGS)
		begin
			sel = '{dev_two: 1'b1, kind: REG_FLAGS};
		end
		// Any other offset stays unmapped
		return sel;
	endfunction

	// Read value of a decoded register
	function automatic word_t read_word(
		input reg_sel_t sel,
		input logic     flags_only,
		input word_t    en1,
		input word_t    fl1,
		input word_t    en2,
		input word_t    fl2
	);
		word_t v;
		v = 16'h0000;
		// Flag registers are visible on both ports
		if (sel.kind == REG_FLAGS)
		begin
			v = sel.dev_two ? fl2 : fl1;
		end
		// Enables only from the processor
		else if (sel.kind == REG_ENABLE && !flags_only)
		begin
			v = sel.dev_two ? en2 : en1;
		end
		// Address is write-only and unmapped reads give zero
		return v;
	endfunction

	// Clear word one port applies to one device
	function automatic word_t clear_word(
		input reg_sel_t sel,
		input logic     wr,
		input logic     want_two,
		input word_t    data
	);
		word_t v;
		v = 16'h0000;
		// Only a write to this device's flag register clears
		if (wr && sel.kind == REG_FLAGS && sel.dev_two == want_two)
		begin
			v = data;
		end
		return v;
	endfunction

	// Assemble the flag-set word of one device
	function automatic word_t set_word(
		input logic [7:0] result,
		input logic [7:0] nak,
		input logic [7:0] nak_ie,
		input logic       sof,
		input logic       usb_rst,
		input logic       vbus_edge,
		input logic       id_edge
	);
		word_t v;
		v = 16'h0000;
		// Endpoint done: result events, plus NAK where allowed
		v[7:0] = result | (nak & nak_ie);
		v[`BIT_SOF] = sof;
		v[`BIT_USB_RST] = usb_rst;
		v[`BIT_VBUS] = vbus_edge;
		v[`BIT_ID] = id_edge;
		return v;
	endfunction

	// Top-level state
	top_state_t s_q;              // Registered state
	top_state_t s_d;              // Next state

	// Decoded selects, device outputs and strobes
	reg_sel_t   cpu_sel;          // Processor decode
	reg_sel_t   hp_sel;           // External host port decode
	word_t      d1_en;            // Device one enables
	word_t      d2_en;            // Device two enables
	word_t      d1_flags;         // Device one flags
	word_t      d2_flags;         // Device two flags
	usb_addr_t  d1_addr;          // Device one address
	usb_addr_t  d2_addr;          // Device two address
	word_t      d1_clr;           // Device one clear word
	word_t      d2_clr;           // Device two clear word
	word_t      d1_set;           // Device one set word
	word_t      d2_set;           // Device two set word
	logic       vbus_edge;        // VBUS crossed the threshold
	logic       id_edge;          // ID pin changed
	logic       d1_en_we;         // Device one enable write
	logic       d2_en_we;         // Device two enable write
	logic       d1_addr_we;       // Device one address write
	logic       d2_addr_we;       // Device two address write
	logic       d1_irq;           // Device one request flop
	logic       d2_irq;           // Device two request flop

	// Address decode for both ports
	always_comb
	begin
		cpu_sel = decode(CPU_ADDR_I);
		hp_sel  = decode(HP_ADDR_I);
	end

	// Processor alone writes enables and address
	always_comb
	begin
		// Host port writes never reach these registers
		d1_en_we   = CPU_WR_I && cpu_sel.kind == REG_ENABLE && !cpu_sel.dev_two;
		d2_en_we   = CPU_WR_I && cpu_sel.kind == REG_ENABLE && cpu_sel.dev_two;
		d1_addr_we = CPU_WR_I && cpu_sel.kind == REG_ADDRESS && !cpu_sel.dev_two;
		d2_addr_we = CPU_WR_I && cpu_sel.kind == REG_ADDRESS && cpu_sel.dev_two;
	end

	// Both ports may clear in the same cycle; clears merge
	always_comb
	begin
		d1_clr = clear_word(cpu_sel, CPU_WR_I, 1'b0, CPU_WDATA_I)
			| clear_word(hp_sel, HP_WR_I, 1'b0, HP_WDATA_I);
		d2_clr = clear_word(cpu_sel, CPU_WR_I, 1'b1, CPU_WDATA_I)
			| clear_word(hp_sel, HP_WR_I, 1'b1, HP_WDATA_I);
	end

	// Edge detection on the OTG levels, held off until a first sample
	always_comb
	begin
		// Primed rises on the first enabled edge after reset
		vbus_edge = s_q.primed && (VBUS_ABOVE_I != s_q.otg_prev[0]);
		id_edge   = s_q.primed && (OTG_ID_I != s_q.otg_prev[1]);
	end

	// Event words; device two has no OTG pins
	always_comb
	begin
		d1_set = set_word(D1_EP_RESULT_I, D1_EP_NAK_I, D1_EP_NAK_IE_I,
			D1_SOF_I, D1_USB_RST_I, vbus_edge, id_edge);
		d2_set = set_word(D2_EP_RESULT_I, D2_EP_NAK_I, D2_EP_NAK_IE_I,
			D2_SOF_I, D2_USB_RST_I, 1'b0, 1'b0);
	end

	// Device one instance, with the OTG flags
	dev_irq_unit #(
		.HAS_OTG   (1'b1)
	) u_dev_one (
		.clk_i     (MCLK_I),
		.rst_i     (SYS_RST_I),
		.ce_i      (CE_I),
		.en_we_i   (d1_en_we),
		.addr_we_i (d1_addr_we),
		.wdata_i   (CPU_WDATA_I),
		.clr_i     (d1_clr),
		.set_i     (d1_set),
		.enables_o (d1_en),
		.address_o (d1_addr),
		.flags_o   (d1_flags),
		.irq_o     (d1_irq)
	);

	// Device two instance, OTG positions reserved
	dev_irq_unit #(
		.HAS_OTG   (1'b0)
	) u_dev_two (
		.clk_i     (MCLK_I),
		.rst_i     (SYS_RST_I),
		.ce_i      (CE_I),
		.en_we_i   (d2_en_we),
		.addr_we_i (d2_addr_we),
		.wdata_i   (CPU_WDATA_I),
		.clr_i     (d2_clr),
		.set_i     (d2_set),
		.enables_o (d2_en),
		.address_o (d2_addr),
		.flags_o   (d2_flags),
		.irq_o     (d2_irq)
	);

	// Next state of reads, edge history and address match
	always_comb
	begin
		s_d = s_q;
		// Read data hold until the next read; valid lasts one cycle
		// Processor read: data one cycle after the strobe
		s_d.cpu_rvalid = CPU_RD_I;
		if (CPU_RD_I)
		begin
			s_d.cpu_rdata = read_word(cpu_sel, 1'b0, d1_en, d1_flags, d2_en, d2_flags);
		end
		// External host port read: flag registers only
		s_d.hp_rvalid = HP_RD_I;
		if (HP_RD_I)
		begin
			s_d.hp_rdata = read_word(hp_sel, 1'b1, d1_en, d1_flags, d2_en, d2_flags);
		end
		// Remember the OTG levels for the next comparison
		s_d.otg_prev = {OTG_ID_I, VBUS_ABOVE_I};
		s_d.primed   = 1'b1;
		// Match is a one-cycle pulse, like the token behind it
		// Answer only tokens aimed at the stored address
		s_d.match[0] = D1_TOKEN_I && (D1_TOKEN_ADDR_I == d1_addr);
		s_d.match[1] = D2_TOKEN_I && (D2_TOKEN_ADDR_I == d2_addr);
	end

	// State register, frozen while the clock enable is low
	always_ff @(posedge MCLK_I)
	begin
		// Reset wins over the clock enable
		if (SYS_RST_I)
		begin
			s_q <= RST_STATE;
		end
		// Everything holds while the clock enable is low
		else if (CE_I)
		begin
			s_q <= s_d;
		end
	end

	// Read ports, straight from flops
	assign CPU_RDATA_O     = s_q.cpu_rdata;
	assign CPU_RVALID_O    = s_q.cpu_rvalid;
	assign HP_RDATA_O      = s_q.hp_rdata;
	assign HP_RVALID_O     = s_q.hp_rvalid;

	// Address match pulses, straight from flops
	assign D1_ADDR_MATCH_O = s_q.match[0];
	assign D2_ADDR_MATCH_O = s_q.match[1];

	// Requests come from the flop inside each device
	assign D1_IRQ_O        = d1_irq;
	assign D2_IRQ_O        = d2_irq;

endmodule

`default_nettype wire

// file: verif/usb_irq_monitor.sv
// Port checks of the device interrupt and address block
`timescale 1ns/1ps
`default_nettype none
`include "usb_irq_regs.svh"
module usb_irq_monitor (
	input wire logic               MCLK_I,          // Clock
	input wire logic               SYS_RST_I,       // Reset
	input wire logic               CE_I,            // Enable
	input wire usb_irq_pkg::word_t CPU_ADDR_I,      // Offset
	input wire logic               CPU_WR_I,        // Write
	input wire logic               CPU_RD_I,        // Read
	input wire usb_irq_pkg::word_t CPU_RDATA_O,     // Data
	input wire logic               CPU_RVALID_O,    // Valid
	input wire usb_irq_pkg::word_t HP_ADDR_I,       // Offset
	input wire logic               HP_WR_I,         // Write
	input wire logic               HP_RD_I,         // Read
	input wire usb_irq_pkg::word_t HP_RDATA_O,      // Data
	input wire logic               HP_RVALID_O,     // Valid
	input wire logic               D1_TOKEN_I,      // Token one
	input wire logic               D2_TOKEN_I,      // Token two
	input wire logic               D1_ADDR_MATCH_O, // Match one
	input wire logic               D2_ADDR_MATCH_O, // Match two
	input wire logic               D1_IRQ_O         // Request one
);
	import usb_irq_pkg::*;
	// One clock domain
	default clocking cb @(posedge MCLK_I);
	endclocking
	default disable iff (SYS_RST_I);
	chk_cpu_rd_valid: assert property
		(CE_I |=> CPU_RVALID_O == $past(CPU_RD_I))
		else $error("cpu read valid wrong");
	chk_hp_rd_valid: assert property
		(CE_I |=> HP_RVALID_O == $past(HP_RD_I))
		else $error("host port read valid wrong");
	chk_addr_write_only: assert property
		(CE_I && CPU_RD_I && CPU_ADDR_I == `OFS_D1_ADDRESS |=> CPU_RDATA_O == 16'h0000)
		else $error("address register readable");
	chk_hp_status_only: assert property
		(CE_I && HP_RD_I && HP_ADDR_I == `OFS_D1_ENABLE |=> HP_RDATA_O == 16'h0000)
		else $error("host port read enables");
	chk_d2_otg_reserved: assert property
		(CE_I && HP_RD_I && HP_ADDR_I == `OFS_D2_FLAGS |=> HP_RDATA_O[15:10] == 6'h00)
		else $error("device two otg bits set");
	chk_match_one_cause: assert property
		($past(CE_I) && D1_ADDR_MATCH_O |-> $past(D1_TOKEN_I))
		else $error("match one without token");
	chk_match_two_cause: assert property
		($past(CE_I) && D2_ADDR_MATCH_O |-> $past(D2_TOKEN_I))
		else $error("match two without token");
	chk_irq_fall_cause: assert property
		($fell(D1_IRQ_O) |-> $past(CPU_WR_I) || $past(HP_WR_I))
		else $error("request fell without write");
endmodule
bind usb_device_irq_and_address usb_irq_monitor mon_u (.MCLK_I(MCLK_I), .SYS_RST_I(SYS_RST_I), .CE_I(CE_I),
	.CPU_ADDR_I(CPU_ADDR_I), .CPU_WR_I(CPU_WR_I), .CPU_RD_I(CPU_RD_I), .CPU_RDATA_O(CPU_RDATA_O),
	.CPU_RVALID_O(CPU_RVALID_O), .HP_ADDR_I(HP_ADDR_I), .HP_WR_I(HP_WR_I), .HP_RD_I(HP_RD_I),
	.HP_RDATA_O(HP_RDATA_O), .HP_RVALID_O(HP_RVALID_O), .D1_TOKEN_I(D1_TOKEN_I), .D2_TOKEN_I(D2_TOKEN_I),
	.D1_ADDR_MATCH_O(D1_ADDR_MATCH_O), .D2_ADDR_MATCH_O(D2_ADDR_MATCH_O), .D1_IRQ_O(D1_IRQ_O));
`default_nettype wire

// file: verif/usb_host_model.sv
// Bus-side source of tokens, endpoint results, frame events and OTG levels
`timescale 1ns/1ps
`default_nettype none
module usb_host_model (
	input  wire logic   clk_i,  // Clock
	output logic [15:0] res_o,  // Results, two:one
	output logic [15:0] nak_o,  // NAKs, two:one
	output logic [1:0]  sof_o,  // SOF/EOP seen
	output logic [1:0]  urst_o, // Bus reset seen
	output logic [1:0]  tok_o,  // Token strobes
	output logic [6:0]  ta_o,   // Token address
	output logic [1:0]  otg_o   // VBUS, ID
);
	// Quiet bus at start
	initial {res_o, nak_o, sof_o, urst_o, tok_o, ta_o, otg_o} = '0;
	// One-cycle event burst for device d
	task automatic ev(input int d, input logic [7:0] r, n, input logic s, u);
		@(posedge clk_i) #1;
		res_o[d*8+:8] = r;
		nak_o[d*8+:8] = n;
		sof_o[d] = s;
		urst_o[d] = u;
		@(posedge clk_i) #1;
		{res_o, nak_o, sof_o, urst_o} = '0;
	endtask
	// One token to device d
	task automatic tok(input int d, input logic [6:0] a);
		@(posedge clk_i) #1;
		tok_o[d] = 1'b1;
		ta_o = a;
		@(posedge clk_i) #1;
		tok_o = 2'b00;
		ta_o = ~a; // Stale address never repeats
	endtask
	// New OTG levels, then settle
	task automatic lv(input logic [1:0] v);
		@(posedge clk_i) #1;
		otg_o = v;
		repeat (2) @(posedge clk_i);
	endtask
endmodule
`default_nettype wire

// file: verif/tb_usb_device_irq_and_address.sv
// Register-level test of the device interrupt and address block
`timescale 1ns/1ps
`default_nettype none
`include "usb_irq_regs.svh"
module tb_usb_device_irq_and_address;
	import usb_irq_pkg::*;
	logic        clk = 1'b0;                       // Clock
	logic        rst = 1'b1;                       // Reset
	word_t       ca, cd, ha, hd, c_rd, h_rd, f, o; // Bus and scratch
	logic        cw, cr, hw, hr, c_rv, h_rv;       // Strobes
	logic        m1, m2, i1, i2;                   // Match, request
	logic [15:0] res, nak, nie;                    // Endpoint events
	logic [1:0]  sof, urst, tok, otg, v, pv;       // Bus events
	logic [6:0]  ta;                               // Token address
	int          error_cnt = 0;                    // Mismatches
	int          n_tests = 0;                      // Comparisons
	always #2.5 clk = ~clk;
	usb_host_model host_u (.clk_i(clk), .res_o(res), .nak_o(nak), .sof_o(sof), .urst_o(urst),
		.tok_o(tok), .ta_o(ta), .otg_o(otg));
	usb_device_irq_and_address dut_u (.MCLK_I(clk), .SYS_RST_I(rst), .CE_I(1'b1),
		.CPU_ADDR_I(ca), .CPU_WR_I(cw), .CPU_RD_I(cr), .CPU_WDATA_I(cd), .CPU_RDATA_O(c_rd), .CPU_RVALID_O(c_rv),
		.HP_ADDR_I(ha), .HP_WR_I(hw), .HP_RD_I(hr), .HP_WDATA_I(hd), .HP_RDATA_O(h_rd), .HP_RVALID_O(h_rv),
		.D1_EP_RESULT_I(res[7:0]), .D1_EP_NAK_I(nak[7:0]), .D1_EP_NAK_IE_I(nie[7:0]), .D1_SOF_I(sof[0]),
		.D1_USB_RST_I(urst[0]), .D2_EP_RESULT_I(res[15:8]), .D2_EP_NAK_I(nak[15:8]), .D2_EP_NAK_IE_I(nie[15:8]),
		.D2_SOF_I(sof[1]), .D2_USB_RST_I(urst[1]), .VBUS_ABOVE_I(otg[1]), .OTG_ID_I(otg[0]),
		.D1_TOKEN_I(tok[0]), .D1_TOKEN_ADDR_I(ta), .D2_TOKEN_I(tok[1]), .D2_TOKEN_ADDR_I(ta),
		.D1_ADDR_MATCH_O(m1), .D2_ADDR_MATCH_O(m2), .D1_IRQ_O(i1), .D2_IRQ_O(i2));
	// Compare and count
	task automatic chk(input word_t got, exp);
		n_tests++;
		if (got !== exp)
			$display("ERROR t=%0t got %h exp %h", $time, got, exp);
		if (got !== exp)
			error_cnt++;
	endtask
	// One access on either port; a read is compared
	task automatic acc(input bit hp, w, input word_t a, d, exp);
		@(posedge clk) #1;
		if (hp)
			{ha, hw, hr, hd} = {a, w, !w, d};
		else
			{ca, cw, cr, cd} = {a, w, !w, d};
		@(posedge clk) #1;
		{hw, hr, cw, cr} = '0;
		if (!w)
			chk(hp ? h_rd : c_rd, exp);
	endtask
	// Verdict
	task automatic stop_test();
		if (error_cnt == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// Hang guard
	initial
	begin
		#50000;
		error_cnt++;
		stop_test();
	end
	// Test sequence
	initial
	begin
		{ca, cd, ha, hd, cw, cr, hw, hr, nie, pv} = '0;
		repeat (6) @(posedge clk);
		#1 rst = 1'b0;
		for (int d = 0; d < 2; d++)
		begin
			acc(0, 0, `OFS_D1_ENABLE + 16'(d * 32), 0, 0);
			acc(0, 0, `OFS_D1_FLAGS + 16'(d * 32), 0, 0);
		end
		acc(0, 1, `OFS_D1_ENABLE, `MASK_EN_D1, 0);
		acc(0, 0, `OFS_D1_ENABLE, 0, `MASK_EN_D1);
		acc(0, 1, `OFS_D2_ENABLE, `MASK_EN_D2, 0);
		acc(0, 0, `OFS_D2_ENABLE, 0, `MASK_EN_D2);
		acc(1, 1, `OFS_D1_ENABLE, 0, 0);
		acc(1, 0, `OFS_D1_ENABLE, 0, 0);
		acc(0, 1, 16'hc092, 16'hffff, 0);
		acc(0, 0, 16'hc092, 0, 0);
		acc(0, 1, `OFS_D1_ENABLE, 16'h001f, 0);
		// Every endpoint: result, enabled NAK, disabled NAK
		for (int j = 0; j < 8; j++)
			for (int k = 0; k < 3; k++)
			begin
				f = (k == 2) ? 16'h0 : 16'(1 << j);
				nie = (k == 1) ? 16'(1 << j) : 16'h0;
				host_u.ev(0, (k == 0) ? 8'(1 << j) : 8'h0, (k == 0) ? 8'h0 : 8'(1 << j), 1'b0, 1'b0);
				chk(16'(i1), 16'(j < 5 && k < 2));
				acc(0, 0, `OFS_D1_FLAGS, 0, f);
				acc(0, 1, `OFS_D1_FLAGS, 0, 0);
				acc(0, 0, `OFS_D1_FLAGS, 0, f);
				acc(0, 1, `OFS_D1_FLAGS, 16'(1 << j), 0);
				acc(0, 0, `OFS_D1_FLAGS, 0, 0);
				chk(16'(i1), 16'h0);
			end
		// Frame and bus reset flags through both ports
		for (int d = 0; d < 2; d++)
		begin
			o = `OFS_D1_FLAGS + 16'(d * 32);
			host_u.ev(d, 8'h0, 8'h0, 1'b1, 1'b1);
			chk(16'(d ? i2 : i1), 16'(d));
			acc(1, 0, o, 0, 16'h0300);
			acc(1, 1, o, 16'h0100, 0);
			acc(0, 0, o, 0, 16'h0200);
			acc(0, 1, o, 16'h0200, 0);
			acc(1, 0, o ^ 16'h0020, 0, 0);
		end
		// Both edges of VBUS and ID
		for (int e = 0; e < 4; e++)
		begin
			v = 2'(8'h12 >> (2 * e));
			host_u.lv(v);
			acc(0, 0, `OFS_D1_FLAGS, 0, {v ^ pv, 14'h0});
			acc(1, 0, `OFS_D2_FLAGS, 0, 0);
			acc(0, 1, `OFS_D1_FLAGS, 16'hc000, 0);
			pv = v;
		end
		// Address filter
		host_u.tok(0, 7'h00);
		chk(16'(m1), 16'h1);
		acc(0, 1, `OFS_D1_ADDRESS, 16'h007f, 0);
		acc(0, 0, `OFS_D1_ADDRESS, 0, 0);
		host_u.tok(0, 7'h7f);
		chk(16'(m1), 16'h1);
		host_u.tok(0, 7'h3f);
		chk(16'(m1), 16'h0);
		host_u.tok(1, 7'h7f);
		chk(16'(m2), 16'h0);
		host_u.tok(1, 7'h00);
		chk(16'(m2), 16'h1);
		stop_test();
	end
endmodule
`default_nettype wire
